// >>> design/mstop_ctrl.sv
// motor stop sequencer, tach output and supply current limiter
// Operation
// - mode 011b slows, then high-side brake
// - below brake speed, brake at once
// - brake time over, all switches off
// - mode 100b ramps target down, then off
// - mode 101b slows, then DC align brake
// - align angle from target or last commutation
// - align brake current capped by align cap
// - behaviour 0: tach active while driving
// - behaviour 1: tach until back-EMF floor
// - divider toggles tach every N+1 cycles
// - closed loop tach tracks drive speed
// - selector 00b: open loop follows drive
// - selector 01b: open loop holds high
// - selector 10b: follow first start only
// - fault drives fixed fault level
// - idle drives fixed idle level
// - spinning gives 50% square wave
// - bus limit on enable, cap setpoint
// - active limit clamps reference below setpoint
// - limit status flag readable
// - no bus limit when active braking
// - 5% hysteresis below bus cap
// - mode 000b turns all off immediately
// - mode 010b like high-side, low switches
`timescale 1ns/100ps
`include "mstop_cfg.svh"
module mstop_ctrl (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 stop_cmd,
    input  wire logic                 fault_active,
    input  wire logic                 open_loop,
    input  wire logic                 first_start_clr,
    input  wire logic                 elec_cycle,
    input  wire logic [15:0]          motor_speed,
    input  wire logic [15:0]          backemf,
    input  wire logic [15:0]          bus_current,
    input  wire logic [15:0]          commut_angle,
    output mstop_pkg::mstop_gate_t    gate_mode,
    output logic      [15:0]          align_angle,
    output logic      [15:0]          current_cap,
    output logic      [15:0]          limited_velocity_target,
    output logic                      tach_out,
    output logic                      bus_limit_active
);
    import mstop_pkg::*;

    // ****************************************
    // register file
    // ****************************************
    logic [4:0]         ctrl;
    logic [15:0]        speed_cmd;
    logic [15:0]        brake_speed;
    logic [15:0]        stop_brake_duration;
    logic [15:0]        spin_down_speed_floor;
    logic [15:0]        align_current_cap;
    logic [15:0]        align_target;
    logic [15:0]        tach_backemf_floor;
    logic [8:0]         tach_cfg;
    logic [15:0]        bus_cap;
    logic               bus_en;
    logic               ack;
    mstop_state_t       state;
    logic               tach_wave;
    logic [31:0]        rd;

    wire logic          req = (avs_read | avs_write) & ~ack;
    wire logic          wr = avs_write & ack;

    // single wait cycle, then accept
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack             <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack             <= req;
            avs_waitrequest <= ~req;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl                  <= 5'h00;
            speed_cmd             <= 16'h0000;
            brake_speed           <= 16'h0000;
            stop_brake_duration   <= `MSTOP_RST_BRAKE_TIME;
            spin_down_speed_floor <= 16'h0000;
            align_current_cap     <= 16'h0000;
            align_target          <= 16'h0000;
            tach_backemf_floor    <= 16'h0000;
            tach_cfg              <= 9'h000;
            bus_cap               <= 16'hffff;
            bus_en                <= 1'b0;
        end else if (wr && avs_byteenable[0]) begin
            case (avs_address)
                `MSTOP_ADDR_CTRL: begin
                    ctrl <= avs_writedata[4:0];
                end
                `MSTOP_ADDR_SPEED: begin
                    speed_cmd   <= avs_writedata[15:0];
                    brake_speed <= avs_writedata[31:16];
                end
                `MSTOP_ADDR_BRAKE: begin
                    stop_brake_duration   <= avs_writedata[15:0];
                    spin_down_speed_floor <= avs_writedata[31:16];
                end
                `MSTOP_ADDR_TACH: begin
                    tach_cfg           <= avs_writedata[8:0];
                    tach_backemf_floor <= avs_writedata[31:16];
                end
                `MSTOP_ADDR_BUS: begin
                    bus_cap <= avs_writedata[15:0];
                    bus_en  <= avs_writedata[16];
                end
                `MSTOP_ADDR_ALIGN: begin
                    align_target      <= avs_writedata[15:0];
                    align_current_cap <= avs_writedata[31:16];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (avs_address)
            `MSTOP_ADDR_CTRL:   rd = {27'h0, ctrl};
            `MSTOP_ADDR_SPEED:  rd = {brake_speed, speed_cmd};
            `MSTOP_ADDR_BRAKE:  rd = {spin_down_speed_floor, stop_brake_duration};
            `MSTOP_ADDR_TACH:   rd = {tach_backemf_floor, 7'h0, tach_cfg};
            `MSTOP_ADDR_BUS:    rd = {15'h0, bus_en, bus_cap};
            `MSTOP_ADDR_STATUS: rd = {24'h0, tach_wave, 2'h0, bus_limit_active, 1'h0, state};
            `MSTOP_ADDR_ALIGN:  rd = {align_current_cap, align_target};
            default:            rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req && avs_read) begin
            avs_readdata <= rd;
        end
    end

    // ****************************************
    // stop sequencer
    // ****************************************
    mstop_mode_t    mode;
    logic [15:0]    brk_cnt;
    logic [15:0]    ramp;
    logic           stop_q;
    logic           braking_mode;
    assign mode = mstop_mode_t'(ctrl[`MSTOP_CTRL_STOP_LSB +: 3]);
    assign braking_mode = (mode == MSTOP_HS_BRK) || (mode == MSTOP_LS_BRK)
                        || (mode == MSTOP_ALIGN);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state   <= MSTOP_IDLE;
            brk_cnt <= 16'h0000;
            ramp    <= 16'h0000;
            stop_q  <= 1'b0;
        end else begin
            stop_q <= stop_cmd;
            case (state)
                MSTOP_IDLE, MSTOP_HIZ: begin
                    if (!stop_cmd && speed_cmd != 16'h0000) begin
                        state <= MSTOP_RUN;
                    end else if (speed_cmd == 16'h0000) begin
                        state <= MSTOP_IDLE;
                    end
                end
                MSTOP_RUN: begin
                    ramp <= motor_speed;
                    if (stop_cmd && !stop_q) begin
                        brk_cnt <= 16'h0000;
                        if (mode == MSTOP_SPIN) begin
                            state <= MSTOP_SLOW;
                        end else if (braking_mode) begin
                            if (motor_speed < brake_speed) begin
                                state <= MSTOP_BRAKE;
                            end else begin
                                state <= MSTOP_SLOW;
                            end
                        end else begin
                            state <= MSTOP_HIZ;
                        end
                    end
                end
                MSTOP_SLOW: begin
                    if (mode == MSTOP_SPIN) begin
                        if (ramp <= spin_down_speed_floor) begin
                            state <= MSTOP_HIZ;
                        end else begin
                            ramp <= ramp - `MSTOP_RAMP_STEP;
                        end
                    end else if (ramp <= brake_speed || motor_speed < brake_speed) begin
                        state <= MSTOP_BRAKE;
                    end else begin
                        ramp <= ramp - `MSTOP_RAMP_STEP;
                    end
                end
                MSTOP_BRAKE: begin
                    brk_cnt <= brk_cnt + 16'h0001;
                    if (brk_cnt + 16'h0001 >= stop_brake_duration) begin
                        state <= MSTOP_HIZ;
                    end
                end
                default: begin
                    state <= MSTOP_IDLE;
                end
            endcase
        end
    end

    a_brake_ends: assert property (@(posedge clock) disable iff (!rst_n)
        (state == MSTOP_BRAKE && brk_cnt + 16'h0001 >= stop_brake_duration)
        |=> state == MSTOP_HIZ) else $error("brake overran its duration");
    a_coast_now: assert property (@(posedge clock) disable iff (!rst_n)
        (state == MSTOP_RUN && stop_cmd && !stop_q && mode == MSTOP_COAST)
        |=> state == MSTOP_HIZ ##1 gate_mode == MSTOP_GATE_OFF)
        else $error("coast did not switch off");

    // ****************************************
    // gate pattern and references
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_mode   <= MSTOP_GATE_OFF;
            align_angle <= 16'h0000;
            current_cap <= 16'h0000;
        end else begin
            gate_mode   <= MSTOP_GATE_OFF;
            current_cap <= bus_cap;
            if (state == MSTOP_BRAKE) begin
                case (mode)
                    MSTOP_HS_BRK: gate_mode <= MSTOP_GATE_HS;
                    MSTOP_LS_BRK: gate_mode <= MSTOP_GATE_LS;
                    MSTOP_ALIGN: begin
                        gate_mode   <= MSTOP_GATE_DC;
                        current_cap <= align_current_cap;
                    end
                    default:      gate_mode <= MSTOP_GATE_OFF;
                endcase
            end else if (state == MSTOP_RUN || state == MSTOP_SLOW) begin
                gate_mode <= MSTOP_GATE_DC;
            end
            align_angle <= ctrl[`MSTOP_CTRL_ALSEL_BIT] ? commut_angle : align_target;
        end
    end

    a_hs_brake: assert property (@(posedge clock) disable iff (!rst_n)
        (state == MSTOP_BRAKE && mode == MSTOP_HS_BRK) |=> gate_mode == MSTOP_GATE_HS)
        else $error("high-side brake pattern missing");
    a_align_cap: assert property (@(posedge clock) disable iff (!rst_n)
        (state == MSTOP_BRAKE && mode == MSTOP_ALIGN) |=> current_cap == $past(align_current_cap))
        else $error("align cap not applied");

    // ****************************************
    // supply current limiter
    // ****************************************
    logic [23:0]    cap_x100;
    logic [23:0]    cur_x100;
    logic [23:0]    cap_low;
    assign cap_x100 = 24'(bus_cap) * 24'(`MSTOP_PCT_SCALE);
    assign cur_x100 = 24'(bus_current) * 24'(`MSTOP_PCT_SCALE);
    assign cap_low  = cap_x100 - 24'(bus_cap) * 24'(`MSTOP_HYST_PCT);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_limit_active        <= 1'b0;
            limited_velocity_target <= 16'h0000;
        end else begin
            if (!bus_en || ctrl[`MSTOP_CTRL_ABRK_BIT]) begin
                bus_limit_active <= 1'b0;
            end else if (cur_x100 > cap_x100) begin
                bus_limit_active <= 1'b1;
            end else if (cur_x100 < cap_low) begin
                bus_limit_active <= 1'b0;
            end
            if (state == MSTOP_SLOW) begin
                limited_velocity_target <= ramp;
            end else if (bus_limit_active && limited_velocity_target > 16'h0000) begin
                limited_velocity_target <= limited_velocity_target - `MSTOP_RAMP_STEP;
            end else if (!bus_limit_active && (state == MSTOP_RUN || state == MSTOP_IDLE)) begin
                limited_velocity_target <= speed_cmd;
            end
        end
    end

    a_limit_off: assert property (@(posedge clock) disable iff (!rst_n)
        (ctrl[`MSTOP_CTRL_ABRK_BIT] || !bus_en) |=> !bus_limit_active)
        else $error("bus limit active while disabled");

    // ****************************************
    // tach output
    // ****************************************
    logic [4:0]     div_cnt;
    logic           first_start;
    logic           driving;
    logic           spinning;
    logic           follow;
    logic [1:0]     ols;
    assign ols = tach_cfg[`MSTOP_TACH_OLS_LSB +: 2];
    assign driving = (state == MSTOP_RUN) || (state == MSTOP_SLOW);
    assign spinning = tach_cfg[`MSTOP_TACH_STOPB_BIT] ? (backemf >= tach_backemf_floor)
                                                      : driving;
    assign follow = !open_loop || ols == 2'b00 || (ols == 2'b10 && first_start);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_start <= 1'b1;
        end else if (first_start_clr) begin
            first_start <= 1'b1;
        end else if (driving && !open_loop) begin
            first_start <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt   <= 5'h00;
            tach_wave <= 1'b0;
        end else if (elec_cycle) begin
            if (div_cnt >= 5'(tach_cfg[`MSTOP_TACH_DIV_LSB +: 4])) begin
                div_cnt   <= 5'h00;
                tach_wave <= ~tach_wave;
            end else begin
                div_cnt <= div_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tach_out <= 1'b0;
        end else if (fault_active) begin
            tach_out <= tach_cfg[`MSTOP_TACH_FLT_BIT];
        end else if (state == MSTOP_IDLE) begin
            tach_out <= tach_cfg[`MSTOP_TACH_IDLE_BIT];
        end else if (spinning && follow) begin
            tach_out <= tach_wave;
        end else if (spinning) begin
            tach_out <= 1'b1;
        end else begin
            tach_out <= tach_cfg[`MSTOP_TACH_IDLE_BIT];
        end
    end

    a_tach_fault: assert property (@(posedge clock) disable iff (!rst_n)
        fault_active |=> tach_out == $past(tach_cfg[`MSTOP_TACH_FLT_BIT]))
        else $error("tach fault level wrong");
    a_tach_ol_high: assert property (@(posedge clock) disable iff (!rst_n)
        (!fault_active && state != MSTOP_IDLE && open_loop && ols == 2'b01 && spinning)
        |=> tach_out) else $error("tach not high in open loop");
endmodule : mstop_ctrl

// >>> design/mstop_cfg.svh
// offsets, field positions, reset values and timing counts for the motor stop and tach block
`ifndef MSTOP_CFG_SVH
`define MSTOP_CFG_SVH
`define MSTOP_ADDR_CTRL      4'h0
`define MSTOP_ADDR_SPEED     4'h1
`define MSTOP_ADDR_BRAKE     4'h2
`define MSTOP_ADDR_TACH      4'h3
`define MSTOP_ADDR_BUS       4'h4
`define MSTOP_ADDR_STATUS    4'h5
`define MSTOP_ADDR_ALIGN     4'h6
`define MSTOP_CTRL_STOP_LSB  0
`define MSTOP_CTRL_ALSEL_BIT 3
`define MSTOP_CTRL_ABRK_BIT  4
`define MSTOP_TACH_DIV_LSB   0
`define MSTOP_TACH_OLS_LSB   4
`define MSTOP_TACH_STOPB_BIT 6
`define MSTOP_TACH_FLT_BIT   7
`define MSTOP_TACH_IDLE_BIT  8
`define MSTOP_RST_BRAKE_TIME 16'h0064
`define MSTOP_RST_TACH_DIV   4'h0
`define MSTOP_RAMP_STEP      16'h0001
`define MSTOP_HYST_PCT       5
`define MSTOP_PCT_SCALE      100
`endif

// >>> design/mstop_pkg.sv
// types shared by the motor stop and tach block
package mstop_pkg;
    typedef enum logic [2:0] {
        MSTOP_COAST  = 3'b000,
        MSTOP_LS_BRK = 3'b010,
        MSTOP_HS_BRK = 3'b011,
        MSTOP_SPIN   = 3'b100,
        MSTOP_ALIGN  = 3'b101
    } mstop_mode_t;
    typedef enum logic [2:0] {
        MSTOP_RUN    = 3'b000,
        MSTOP_SLOW   = 3'b001,
        MSTOP_BRAKE  = 3'b010,
        MSTOP_HIZ    = 3'b011,
        MSTOP_IDLE   = 3'b100
    } mstop_state_t;
    typedef enum logic [1:0] {
        MSTOP_GATE_OFF = 2'b00,
        MSTOP_GATE_HS  = 2'b01,
        MSTOP_GATE_LS  = 2'b10,
        MSTOP_GATE_DC  = 2'b11
    } mstop_gate_t;
endpackage : mstop_pkg

// >>> tb/mstop_motor.sv
// motor windings and power stage model for the stop and tach bench
`timescale 1ns/100ps
module mstop_motor (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire mstop_pkg::mstop_gate_t gate_mode,
    input  wire logic                   freeze,
    input  wire logic [15:0]            limited_velocity_target,
    output logic      [15:0]            motor_speed,
    output logic      [15:0]            backemf,
    output logic                        elec_cycle,
    output logic      [15:0]            commut_angle
);
    import mstop_pkg::*;
    logic [2:0] phase;
    // driven or DC align braked rotor follows target, high-side or low-side brake or coast lets it decay
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            motor_speed <= 16'h0000;
        end else if (gate_mode == MSTOP_GATE_DC) begin
            motor_speed <= limited_velocity_target;
        end else if (motor_speed > 16'h0003) begin
            motor_speed <= motor_speed - 16'h0004;
        end else begin
            motor_speed <= 16'h0000;
        end
    end
    // one electrical cycle every eight clocks while turning
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 3'h0;
            elec_cycle <= 1'h0;
            commut_angle <= 16'h0000;
        end else begin
            phase <= phase + 3'h1;
            elec_cycle <= (phase == 3'h7) && (motor_speed != 16'h0000);
            if (elec_cycle && !freeze) begin
                commut_angle <= commut_angle + 16'h0400;
            end
        end
    end
    assign backemf = motor_speed;
endmodule : mstop_motor

// >>> tb/mstop_ctrl_bench.sv
// self-checking bench for the motor stop and tach block
`timescale 1ns/100ps
`include "mstop_cfg.svh"
module mstop_ctrl_bench;
    import mstop_pkg::*;
    localparam int LIM = 3000;
    logic        clock = 1'h0;
    logic        rst_n = 1'h0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        stop_cmd = 1'h0;
    logic        fault_active = 1'h0;
    logic        open_loop = 1'h0;
    logic        first_start_clr = 1'h0;
    logic        freeze = 1'h0;
    logic        elec_cycle;
    logic [15:0] motor_speed;
    logic [15:0] backemf;
    logic [15:0] bus_current = 16'h0;
    logic [15:0] commut_angle;
    mstop_gate_t gate_mode;
    logic [15:0] align_angle;
    logic [15:0] current_cap;
    logic [15:0] limited_velocity_target;
    logic        tach_out;
    logic        bus_limit_active;
    logic [31:0] rd;
    logic [15:0] cur [5] = '{16'h0101, 16'h00f4, 16'h00f2, 16'h0100, 16'h0101};
    int          fail_count = 0;
    int          checks_done = 0;
    int          pre_n, hold_n, run_n, pulses, d, hi, p;

    always #2.5 clock = ~clock;

    mstop_ctrl mstop_ctrl_i (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .stop_cmd(stop_cmd), .fault_active(fault_active), .open_loop(open_loop),
        .first_start_clr(first_start_clr), .elec_cycle(elec_cycle),
        .motor_speed(motor_speed), .backemf(backemf), .bus_current(bus_current),
        .commut_angle(commut_angle), .gate_mode(gate_mode), .align_angle(align_angle),
        .current_cap(current_cap), .limited_velocity_target(limited_velocity_target),
        .tach_out(tach_out), .bus_limit_active(bus_limit_active));
    mstop_motor mstop_motor_i (
        .clock(clock), .rst_n(rst_n), .gate_mode(gate_mode), .freeze(freeze),
        .limited_velocity_target(limited_velocity_target), .motor_speed(motor_speed),
        .backemf(backemf), .elec_cycle(elec_cycle), .commut_angle(commut_angle));

    // ****************
    // tasks
    // ****************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 64);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (n >= 64) begin
            chk("waitrequest", 32'h0, 32'h1);
            finish_test();
        end
    endtask : bus

    task automatic wait_gate(input mstop_gate_t g);
        pre_n = 0;
        while (gate_mode !== g && pre_n < LIM) begin
            @(posedge clock);
            pre_n++;
        end
        if (pre_n >= LIM) begin
            chk("gate_timeout", 32'h0, 32'h1);
            finish_test();
        end
    endtask : wait_gate

    task automatic count_high(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clock);
            hi += int'(tach_out === 1'h1);
        end
    endtask : count_high

    task automatic hold_len(input logic v);
        run_n = 0;
        pulses = 0;
        while (tach_out === v && run_n < LIM) begin
            @(posedge clock);
            run_n++;
            pulses += int'(elec_cycle);
        end
        if (run_n >= LIM) begin
            chk("tach_timeout", 32'h0, 32'h1);
            finish_test();
        end
    endtask : hold_len

    task automatic restart(input logic [31:0] ctrl, input logic [31:0] speed);
        rst_n <= 1'h0;
        stop_cmd <= 1'h0;
        fault_active <= 1'h0;
        open_loop <= 1'h0;
        freeze <= 1'h0;
        bus_current <= 16'h0000;
        repeat (16) @(posedge clock);
        rst_n <= 1'h1;
        if (speed != 32'h0) begin
            bus(1'h1, `MSTOP_ADDR_BRAKE, 32'h0020_0014);
            bus(1'h1, `MSTOP_ADDR_CTRL, ctrl);
            bus(1'h1, `MSTOP_ADDR_SPEED, speed);
            wait_gate(MSTOP_GATE_DC);
            repeat (100) @(posedge clock);
        end
    endtask : restart

    task automatic stop_seq(input logic [31:0] ctrl, input logic [15:0] entry,
                            input mstop_gate_t g);
        restart(ctrl, {entry, 16'h0040});
        stop_cmd <= 1'h1;
        wait_gate(g);
        chk("entry_speed", 32'h1, 32'(motor_speed <= entry));
        hold_n = 0;
        while (gate_mode === g && hold_n < LIM) begin
            @(posedge clock);
            hold_n++;
        end
        chk("brake_len", 32'h1, 32'(hold_n >= 20 && hold_n <= 23));
        if (hold_n >= LIM) begin
            finish_test();
        end
        chk("stop_off", 32'(MSTOP_GATE_OFF), 32'(gate_mode));
    endtask : stop_seq

    // ****************
    // scenarios
    // ****************
    initial begin
        restart(32'h0, 32'h0);
        bus(1'h0, `MSTOP_ADDR_BRAKE, 32'h0);
        chk("brake_rst", 32'h0064, rd & 32'h0000_ffff);
        bus(1'h0, `MSTOP_ADDR_BUS, 32'h0);
        chk("bus_rst", 32'h0000_ffff, rd & 32'h0001_ffff);
        bus(1'h1, 4'h9, 32'hffff_ffff);
        bus(1'h0, 4'h9, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'h0, `MSTOP_ADDR_STATUS, 32'h0);
        chk("idle_state", 32'(MSTOP_IDLE), {29'h0, rd[2:0]});
        for (int i = 0; i < 2; i++) begin
            bus(1'h1, `MSTOP_ADDR_TACH, (i == 0) ? 32'h0000_0080 : 32'h0000_0100);
            repeat (4) @(posedge clock);
            chk("tach_idle", 32'(i), 32'(tach_out));
            fault_active <= 1'h1;
            repeat (4) @(posedge clock);
            chk("tach_fault", 32'(i == 0), 32'(tach_out));
            fault_active <= 1'h0;
        end
        stop_seq(32'h3, 16'h0080, MSTOP_GATE_HS);
        chk("hs_direct", 32'h1, 32'(pre_n <= 3));
        stop_seq(32'h2, 16'h0010, MSTOP_GATE_LS);
        chk("ls_slows", 32'h1, 32'(pre_n > 20));
        for (int m = 0; m < 8; m += 7) begin
            restart(32'(m), 32'h0010_0040);
            stop_cmd <= 1'h1;
            repeat (3) @(posedge clock);
            chk("coast", 32'(MSTOP_GATE_OFF), 32'(gate_mode));
        end
        restart(32'h4, 32'h0080_0040);
        stop_cmd <= 1'h1;
        wait_gate(MSTOP_GATE_OFF);
        chk("spin_floor", 32'h0020, {16'h0, limited_velocity_target});
        chk("spin_ramp", 32'h1, 32'(pre_n >= 30 && pre_n < LIM));
        for (int s = 0; s < 2; s++) begin
            restart(32'h5 | 32'(s << 3), 32'h0080_0040);
            freeze <= 1'h1;
            bus(1'h1, `MSTOP_ADDR_ALIGN, 32'h0200_1234);
            stop_cmd <= 1'h1;
            bus(1'h0, `MSTOP_ADDR_STATUS, 32'h0);
            chk("al_state", 32'(MSTOP_BRAKE), {29'h0, rd[2:0]});
            chk("al_angle", (s == 0) ? 32'h1234 : 32'(commut_angle), 32'(align_angle));
            chk("al_cap", 32'h0200, {16'h0, current_cap});
            chk("al_gate", 32'(MSTOP_GATE_DC), 32'(gate_mode));
        end
        restart(32'h0, 32'h0080_0040);
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 0 : (k == 1) ? 3 : 14;
            bus(1'h1, `MSTOP_ADDR_TACH, 32'(d) | ((k == 2) ? 32'h0020_0040 : 32'h0));
            hold_len(1'h1);
            hold_len(1'h0);
            hold_len(1'h1);
            hi = run_n;
            p = pulses;
            hold_len(1'h0);
            chk("tach_duty", 32'(hi), 32'(run_n));
            chk("tach_div", 32'(d + 1), 32'(p));
        end
        bus(1'h1, `MSTOP_ADDR_TACH, 32'h0080_0140);
        repeat (4) @(posedge clock);
        count_high(64);
        chk("tach_floor", 32'd64, 32'(hi));
        open_loop <= 1'h1;
        bus(1'h1, `MSTOP_ADDR_TACH, 32'h0000_0010);
        repeat (2) @(posedge clock);
        count_high(400);
        chk("ol_high", 32'd400, 32'(hi));
        for (int s = 0; s < 2; s++) begin
            first_start_clr <= 1'h1;
            bus(1'h1, `MSTOP_ADDR_TACH, (s == 0) ? 32'h0000_0000 : 32'h0000_0020);
            first_start_clr <= 1'h0;
            hold_len(1'h1);
            hold_len(1'h0);
            hold_len(1'h1);
            chk("ol_follow", 32'h1, 32'(pulses));
        end
        open_loop <= 1'h0;
        repeat (20) @(posedge clock);
        open_loop <= 1'h1;
        repeat (4) @(posedge clock);
        count_high(64);
        chk("ol_later", 32'd64, 32'(hi));
        restart(32'h0, 32'h0080_0040);
        bus(1'h1, `MSTOP_ADDR_BUS, 32'h0001_0100);
        for (int k = 0; k < 5; k++) begin
            bus_current <= cur[k];
            repeat (4) @(posedge clock);
            chk("bus_lim", 32'(k != 2 && k != 3), 32'(bus_limit_active));
        end
        repeat (16) @(posedge clock);
        chk("clamp", 32'h1, 32'(limited_velocity_target < 16'h0040));
        bus(1'h0, `MSTOP_ADDR_STATUS, 32'h0);
        chk("lim_flag", 32'h1, {31'h0, rd[4]});
        bus(1'h1, `MSTOP_ADDR_CTRL, 32'h0000_0010);
        repeat (4) @(posedge clock);
        chk("lim_abrk", 32'h0, 32'(bus_limit_active));
        bus(1'h1, `MSTOP_ADDR_CTRL, 32'h0);
        bus(1'h1, `MSTOP_ADDR_BUS, 32'h0000_0100);
        repeat (4) @(posedge clock);
        chk("lim_off", 32'h0, 32'(bus_limit_active));
        finish_test();
    end
endmodule : mstop_ctrl_bench
